// *** smp_pin_ctrl.sv ***
`include "smp_regs.svh"

module smp_pin_ctrl #(
  parameter int HS_PULSE_CYC  = `SMP_HS_PULSE_US * `SMP_CLK_MHZ,
  parameter int IRQ_PULSE_CYC = `SMP_IRQ_PULSE_US * `SMP_CLK_MHZ,
  parameter int IRQ_GAP_CYC   = `SMP_IRQ_GAP_US * `SMP_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Detection event sources and flag register read
  input  wire logic       hs_det_i,
  input  wire logic       btn_i,
  input  wire logic       short_i,
  input  wire logic       noise_i,
  input  wire logic       flag_read_i,
  // Serial bus bit clock
  input  wire logic       bclk_dir_out_i,
  input  wire logic       bclk_src_i,
  output logic            bclk_o,
  // Microphone data
  input  wire logic       mic_clk_i,
  output logic            mic_rise_o,
  output logic            mic_fall_o,
  output logic            mic_valid_o,
  // Pin
  input  wire logic       pin_i,
  output logic            pin_o,
  output logic            pin_oe_o,
  // Interrupt
  output logic            irq_o
);
  import smp_pkg::*;

  localparam logic [`SMP_CNT_W-1:0] HS_LEN  = HS_PULSE_CYC[`SMP_CNT_W-1:0];
  localparam logic [`SMP_CNT_W-1:0] IRQ_LEN = IRQ_PULSE_CYC[`SMP_CNT_W-1:0];
  localparam logic [`SMP_CNT_W-1:0] GAP_LEN = IRQ_GAP_CYC[`SMP_CNT_W-1:0];

  smp_state_t st;
  smp_state_t next_st;

  //----------------------------------------------------------------------------
  // Function decoding
  //----------------------------------------------------------------------------

  // Map a function code onto a pin usage
  function automatic smp_mode_t smp_decode(input logic [3:0] fn);
    smp_mode_t m;
    m = SMP_OFF;
    unique case (fn)
      `SMP_FN_OFF, `SMP_FN_RSVD, `SMP_FN_UNUSED: m = SMP_OFF; // RL1 RL13
      `SMP_FN_GPI:                               m = SMP_GPI; // RL4
      `SMP_FN_GPO:                               m = SMP_GPO; // RL4
      `SMP_FN_MIC_A, `SMP_FN_MIC_B, `SMP_FN_MIC_C: m = SMP_MIC; // RL5
      `SMP_FN_BCLK:                              m = SMP_BCLK; // RL6
      `SMP_FN_HS, `SMP_FN_HS_BTN, `SMP_FN_ALL, `SMP_FN_HS_NS,
      `SMP_FN_SC, `SMP_FN_SC_NS, `SMP_FN_BTN:   m = SMP_IRQ;
    endcase
    return m;
  endfunction

  // Combine detection events as the function code selects
  function automatic logic smp_source(input logic [3:0] fn, input logic hs,
                                      input logic btn, input logic sc,
                                      input logic ns);
    logic s;
    s = 1'b0;
    case (fn)
      `SMP_FN_HS:     s = hs;                    // RL3
      `SMP_FN_HS_BTN: s = hs | btn;              // RL7
      `SMP_FN_ALL:    s = hs | btn | sc | ns;    // RL8
      `SMP_FN_HS_NS:  s = hs | ns;               // RL9
      `SMP_FN_SC_NS:  s = sc | ns;               // RL10
      `SMP_FN_SC:     s = sc;                    // RL11
      `SMP_FN_BTN:    s = btn;                   // RL12
      default:        s = 1'b0;
    endcase
    return s;
  endfunction

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------

  // Whole block behaviour in one pass
  always_comb begin
    smp_mode_t            mode;
    logic                 event_in;
    logic                 mic_rise_edge;
    logic                 mic_fall_edge;
    logic                 pulse_start;
    logic [`SMP_CNT_W-1:0] len;
    logic [`SMP_EV_W-1:0] ev;
    logic [`SMP_EV_W-1:0] clr;

    next_st = st;
    mode = smp_decode(st.fn);
    event_in = smp_source(st.fn, hs_det_i, btn_i, short_i, noise_i);
    mic_rise_edge = mic_clk_i & ~st.mic_clk_q;
    mic_fall_edge = ~mic_clk_i & st.mic_clk_q;
    pulse_start = 1'b0;
    len = (st.fn == `SMP_FN_HS) ? HS_LEN : IRQ_LEN; // RL3 RL16
    ev = '0;
    clr = '0;

    // Sample the pin every cycle for reads and edge events
    next_st.pin_q = pin_i;                       // RL15
    next_st.pin_prev = st.pin_q;
    next_st.mic_clk_q = mic_clk_i;
    next_st.bclk = st.pin_q;

    // Control register write; input value bit is not writable
    if (wr_i && addr_i == `SMP_ADDR_CTRL) begin
      next_st.fn = wdata_i[`SMP_FN_HI:`SMP_FN_LO];
      next_st.gpo = wdata_i[`SMP_GPO_BIT];       // RL14
      next_st.dur = wdata_i[`SMP_DUR_BIT];
      next_st.rsv = wdata_i[`SMP_RSV_BIT];       // RL18
    end
    if (wr_i && addr_i == `SMP_ADDR_MASK) begin
      next_st.msk = wdata_i[`SMP_EV_W-1:0];
    end
    if (wr_i && addr_i == `SMP_ADDR_STATUS) begin
      clr = wdata_i[`SMP_EV_W-1:0];
    end

    // Interrupt pulse generator
    if (mode != SMP_IRQ) begin
      next_st.pst = PS_IDLE;
      next_st.cnt = '0;
      next_st.armed = 1'b0;
    end else begin
      // Host read of the flag register stops repetition
      if (flag_read_i) begin
        next_st.armed = 1'b0;                    // RL17
      end
      if (event_in && st.dur) begin
        next_st.armed = 1'b1;                    // RL17
      end
      unique case (st.pst)
        PS_IDLE: begin
          if (event_in) begin
            next_st.pst = PS_HIGH;               // RL16
            next_st.cnt = len;
            pulse_start = 1'b1;
          end
        end
        PS_HIGH: begin
          if (st.cnt > 1) begin
            next_st.cnt = st.cnt - 1'b1;
          end else if (st.dur && next_st.armed) begin
            next_st.pst = PS_GAP;                // RL17
            next_st.cnt = GAP_LEN;
          end else begin
            next_st.pst = PS_IDLE;               // RL16
            next_st.cnt = '0;
          end
        end
        PS_GAP: begin
          if (!next_st.armed) begin
            next_st.pst = PS_IDLE;               // RL17
            next_st.cnt = '0;
          end else if (st.cnt > 1) begin
            next_st.cnt = st.cnt - 1'b1;
          end else begin
            next_st.pst = PS_HIGH;               // RL17
            next_st.cnt = len;
            pulse_start = 1'b1;
          end
        end
        // Unused code recovers to idle
        default: begin
          next_st.pst = PS_IDLE;
          next_st.cnt = '0;
        end
      endcase
    end

    // Microphone data taken on both clock edges
    next_st.mic_valid = 1'b0;
    if (mode == SMP_MIC) begin
      if (mic_rise_edge) begin
        next_st.mic_rise = pin_i;                // RL5
      end
      if (mic_fall_edge) begin
        next_st.mic_fall = pin_i;                // RL5
        next_st.mic_valid = 1'b1;
      end
    end

    // Pin drive according to usage
    unique case (mode)
      SMP_OFF, SMP_GPI, SMP_MIC: begin
        next_st.pin_o = 1'b0;                    // RL1 RL4
        next_st.pin_oe = 1'b0;
      end
      SMP_GPO: begin
        next_st.pin_o = st.gpo;                  // RL4 RL14
        next_st.pin_oe = 1'b1;
      end
      SMP_BCLK: begin
        next_st.pin_o = bclk_dir_out_i & bclk_src_i; // RL6
        next_st.pin_oe = bclk_dir_out_i;
      end
      SMP_IRQ: begin
        next_st.pin_o = (next_st.pst == PS_HIGH);
        next_st.pin_oe = 1'b1;
      end
    endcase

    // Sticky events: set beats clear
    if (mode == SMP_GPI) begin
      ev[`SMP_EV_RISE] = st.pin_q & ~st.pin_prev;
      ev[`SMP_EV_FALL] = ~st.pin_q & st.pin_prev;
    end
    ev[`SMP_EV_PULSE] = pulse_start;
    next_st.sts = (st.sts & ~clr) | ev;
    next_st.irq = |(next_st.sts & next_st.msk);

    // Read data valid only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `SMP_ADDR_CTRL:   next_st.rdata = {st.fn, st.gpo, st.pin_q, st.dur, st.rsv}; // RL15
        `SMP_ADDR_STATUS: next_st.rdata = {{(8-`SMP_EV_W){1'b0}}, st.sts};
        `SMP_ADDR_MASK:   next_st.rdata = {{(8-`SMP_EV_W){1'b0}}, st.msk};
        default:          next_st.rdata = 8'h00;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------

  // Reset clears everything, function field to disabled
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;                                  // RL1
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign rdata_o     = st.rdata;
  assign bclk_o      = st.bclk;
  assign mic_rise_o  = st.mic_rise;
  assign mic_fall_o  = st.mic_fall;
  assign mic_valid_o = st.mic_valid;
  assign pin_o       = st.pin_o;
  assign pin_oe_o    = st.pin_oe;
  assign irq_o       = st.irq;

endmodule

// *** smp_regs.svh ***
//------------------------------------------------------------------------------
// Second multi-function pin control: constants
//------------------------------------------------------------------------------
// Summary of operation
// RL1: Function field bits 7..4 resets to 0000; pin then neither drives nor listens. The code still samples the pin into bit 2 and bclk_o in every mode.
// RL2: Software never writes reserved function code 0001.
// RL3: Code 0010 drives headset detect interrupt, active high, about 1.75 ms long.
// RL4: Code 0011 is general input; code 0100 is general output from value bit.
// RL5: Codes 0101..0111 take microphone data, sampled on both microphone clock edges.
// RL6: Code 1000 makes pin the serial bus bit clock; direction from bus setup.
// RL7: Code 1001 drives headset OR button interrupt.
// RL8: Code 1010 drives headset OR button OR short circuit OR noise interrupt.
// RL9: Code 1011 drives headset OR noise interrupt.
// RL10: Code 1110 drives short circuit OR noise interrupt.
// RL11: Code 1101 drives short circuit interrupt alone.
// RL12: Code 1111 drives button or hook-switch interrupt; noise-only code conflicts.
// RL13: Unprinted code 1100 decodes as a disabled pin.
// RL14: Bit 3 sets general output level, resets to zero.
// RL15: Read-only bit 2 shows the sampled pin level; writes ignored.
// RL16: Bit 1 zero: each interrupt is one active-high pulse of about 2 ms (about 1.75 ms for code 0010).
// RL17: Bit 1 one: interrupt pulses repeat until host reads flag register 96.
// RL18: Software writes only zero to reserved bit 0.
`ifndef SMP_REGS_SVH
`define SMP_REGS_SVH

//------------------------------------------------------------------------------
// Register map
//------------------------------------------------------------------------------
`define SMP_ADDR_CTRL    8'h63
`define SMP_ADDR_STATUS  8'h68
`define SMP_ADDR_MASK    8'h69
`define SMP_CTRL_RESET   8'h00

// Control field positions
`define SMP_FN_HI        7
`define SMP_FN_LO        4
`define SMP_GPO_BIT      3
`define SMP_GPI_BIT      2
`define SMP_DUR_BIT      1
`define SMP_RSV_BIT      0

// Status and mask bits
`define SMP_EV_W         3
`define SMP_EV_RISE      0
`define SMP_EV_FALL      1
`define SMP_EV_PULSE     2

// Function codes
`define SMP_FN_OFF       4'h0
`define SMP_FN_RSVD      4'h1
`define SMP_FN_HS        4'h2
`define SMP_FN_GPI       4'h3
`define SMP_FN_GPO       4'h4
`define SMP_FN_MIC_A     4'h5
`define SMP_FN_MIC_B     4'h6
`define SMP_FN_MIC_C     4'h7
`define SMP_FN_BCLK      4'h8
`define SMP_FN_HS_BTN    4'h9
`define SMP_FN_ALL       4'hA
`define SMP_FN_HS_NS     4'hB
`define SMP_FN_UNUSED    4'hC
`define SMP_FN_SC        4'hD
`define SMP_FN_SC_NS     4'hE
`define SMP_FN_BTN       4'hF

//------------------------------------------------------------------------------
// Timing
//------------------------------------------------------------------------------
`define SMP_CLK_MHZ      40
`define SMP_HS_PULSE_US  1750
`define SMP_IRQ_PULSE_US 2000
`define SMP_IRQ_GAP_US   2000
`define SMP_CNT_W        17

`endif

// *** smp_pkg.sv ***
`include "smp_regs.svh"

package smp_pkg;

  // Pin usage derived from the function field
  typedef enum logic [2:0] {
    SMP_OFF, SMP_IRQ, SMP_GPI, SMP_GPO, SMP_MIC, SMP_BCLK
  } smp_mode_t;

  // Interrupt pulse generator states
  typedef enum logic [1:0] {
    PS_IDLE, PS_HIGH, PS_GAP
  } smp_pst_t;

  // Complete state of the block
  typedef struct packed {
    logic [3:0]            fn;
    logic                  gpo;
    logic                  dur;
    logic                  rsv;
    logic                  pin_q;
    logic                  pin_prev;
    smp_pst_t              pst;
    logic [`SMP_CNT_W-1:0] cnt;
    logic                  armed;
    logic                  mic_clk_q;
    logic                  mic_rise;
    logic                  mic_fall;
    logic                  mic_valid;
    logic                  bclk;
    logic                  pin_o;
    logic                  pin_oe;
    logic [`SMP_EV_W-1:0]  sts;
    logic [`SMP_EV_W-1:0]  msk;
    logic                  irq;
    logic [7:0]            rdata;
  } smp_state_t;

endpackage

// *** smp_chk.sv ***
`include "smp_regs.svh"

module smp_chk #(
  parameter int HS_PULSE_CYC  = 7,
  parameter int IRQ_PULSE_CYC = 8,
  parameter int IRQ_GAP_CYC   = 5
) (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // Pin side
  input wire logic       flag_read_i,
  input wire logic       bclk_dir_out_i,
  input wire logic       pin_o,
  input wire logic       pin_oe_o
);
  logic [7:0] sh;
  logic       fg;
  logic [`SMP_CNT_W-1:0] hi;
  logic [`SMP_CNT_W-1:0] lo;
  logic                  wt;
  logic       gpo;
  logic       irqc;

  //----------------------------------------------------------------------------
  // Helper logic
  //----------------------------------------------------------------------------
  // Shadow of the control byte, flag-read memory, pin high and low counts,
  // and a flag that a repeating pulse has ended and its gap is running
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= 8'h00;
      fg <= 1'b0;
      hi <= '0;
      lo <= '0;
      wt <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && addr_i == `SMP_ADDR_CTRL) sh <= wdata_i;
      fg <= (wr_i && addr_i == `SMP_ADDR_CTRL) ? 1'b0 : (fg | flag_read_i);
      hi <= pin_o ? hi + 1'b1 : '0;
      lo <= pin_o ? '0 : lo + 1'b1;
      // A flag read or a new setup may end repetition: stop watching then
      if (pin_o || flag_read_i || (wr_i && addr_i == `SMP_ADDR_CTRL)) wt <= 1'b0;
      else if (hi != '0 && irqc && sh[1] && !fg) wt <= 1'b1;
    end
  end
  // Field views
  assign gpo  = sh[3];
  assign irqc = sh[7:4] inside {4'h2, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};

  //----------------------------------------------------------------------------
  // Properties
  //----------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Gap after a repeating pulse has run its full length
  sequence s_gap_done;
    wt && int'(lo) == IRQ_GAP_CYC;
  endsequence
  property p_gap;
    s_gap_done |-> pin_o;
  endproperty
  a_gap: assert property (p_gap) else $error("repeat pulse missing");
  property p_width;
    $fell(pin_o) && irqc && $past(irqc) |->
      int'(hi) == ((sh[7:4] == 4'h2) ? HS_PULSE_CYC : IRQ_PULSE_CYC);
  endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_rd_idle;
    ce_i && !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_rd_ctrl;
    rd_i && addr_i == `SMP_ADDR_CTRL |=> (rdata_o & 8'hFB) == ($past(sh) & 8'hFB);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
  property p_off;
    sh[7:4] inside {4'h0, 4'h1, 4'hC} |=> !pin_oe_o;
  endproperty
  a_off: assert property (p_off) else $error("disabled pin driven");
  property p_gpo;
    sh[7:4] == 4'h4 |=> pin_oe_o && pin_o == $past(gpo);
  endproperty
  a_gpo: assert property (p_gpo) else $error("output level wrong");
  property p_irq_oe;
    irqc |=> pin_oe_o;
  endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("interrupt pin not driven");
  property p_bclk;
    sh[7:4] == 4'h8 |=> pin_oe_o == $past(bclk_dir_out_i);
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock direction wrong");
endmodule

bind smp_pin_ctrl smp_chk #(.HS_PULSE_CYC(HS_PULSE_CYC), .IRQ_PULSE_CYC(IRQ_PULSE_CYC),
  .IRQ_GAP_CYC(IRQ_GAP_CYC)) i_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .flag_read_i(flag_read_i), .bclk_dir_out_i(bclk_dir_out_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o));

// *** smp_board.sv ***
module smp_board (
  // Clock
  input  wire logic mclk_i,
  // Device drive and board drive
  input  wire logic pin_o,
  input  wire logic pin_oe_o,
  input  wire logic drv_i,
  input  wire logic val_i,
  // Resolved pin level
  output logic      pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic flip = 1'b0;
  // Undriven pin wanders so a floating level never reads as stable
  always_ff @(posedge mclk_i) flip <= ~flip;
  // Wire level from both parties' drives
  always_comb pin_i = pin_oe_o ? pin_o : (drv_i ? val_i : flip);
endmodule

// *** tb.sv ***
`include "smp_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] CODE [7] = '{4'h2, 4'h9, 4'hA, 4'hB, 4'hE, 4'hD, 4'hF};
  localparam logic [3:0] SRCM [7] = '{4'h8, 4'hC, 4'hF, 4'h9, 4'h3, 4'h2, 4'h4};
  logic       mclk, rst, wr, rd, flag, bdir, bsrc, mck, drv, val, ce;
  logic [3:0] src;
  logic [7:0] addr, wdata, rdata;
  logic       bclk, mrise, mfall, mval, pin_i, pin_o, pin_oe, irq;
  int         mismatches, checked;

  smp_pin_ctrl #(.HS_PULSE_CYC(7), .IRQ_PULSE_CYC(8), .IRQ_GAP_CYC(5)) i_dut (
    .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .hs_det_i(src[3]), .btn_i(src[2]),
    .short_i(src[1]), .noise_i(src[0]), .flag_read_i(flag), .bclk_dir_out_i(bdir),
    .bclk_src_i(bsrc), .bclk_o(bclk), .mic_clk_i(mck), .mic_rise_o(mrise),
    .mic_fall_o(mfall), .mic_valid_o(mval), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe), .irq_o(irq));
  smp_board i_board (.mclk_i(mclk), .pin_o(pin_o), .pin_oe_o(pin_oe), .drv_i(drv),
    .val_i(val), .pin_i(pin_i));

  //----------------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask
  task automatic close_out();
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  //----------------------------------------------------------------------------
  // Clock, watchdog and tests
  //----------------------------------------------------------------------------
  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Hang guard
  initial begin
    #100us;
    mismatches++;
    close_out();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {wr, rd, flag, bdir, bsrc, mck, val} = 7'h00;
    {drv, ce} = 2'h3;
    src = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(`SMP_ADDR_CTRL, `SMP_CTRL_RESET);
    chk("oe", 8'h00, {7'h0, pin_oe});
    wr_reg(`SMP_ADDR_CTRL, 8'h48);
    tick(2);
    chk("gpo", 8'h03, {6'h0, pin_oe, pin_o});
    rd_reg(`SMP_ADDR_CTRL, 8'h4C);
    // Clock enable low: a write must not take and the pin must hold
    @(posedge mclk) ce <= 1'b0;
    wr_reg(`SMP_ADDR_CTRL, 8'h40);
    tick(2);
    chk("frozen", 8'h03, {6'h0, pin_oe, pin_o});
    @(posedge mclk) ce <= 1'b1;
    wr_reg(`SMP_ADDR_CTRL, 8'h40);
    tick(2);
    chk("gpo", 8'h02, {6'h0, pin_oe, pin_o});
    // General input, with a write to the read-only bit
    wr_reg(`SMP_ADDR_CTRL, 8'h34);
    rd_reg(`SMP_ADDR_CTRL, 8'h30);
    @(posedge mclk) val <= 1'b1;
    tick(4);
    rd_reg(`SMP_ADDR_CTRL, 8'h34);
    rd_reg(`SMP_ADDR_STATUS, 8'h01);
    wr_reg(`SMP_ADDR_MASK, 8'h01);
    tick(2);
    chk("irq", 8'h01, {7'h0, irq});
    wr_reg(`SMP_ADDR_STATUS, 8'h01);
    @(posedge mclk) val <= 1'b0;
    tick(4);
    chk("irq", 8'h00, {7'h0, irq});
    rd_reg(`SMP_ADDR_STATUS, 8'h02);
    rd_reg(8'h64, 8'h00);
    wr_reg(`SMP_ADDR_STATUS, 8'h03);
    wr_reg(`SMP_ADDR_MASK, 8'h04);
    // Every interrupt code against every single source
    for (int c = 0; c < 7; c++) begin
      wr_reg(`SMP_ADDR_CTRL, {CODE[c], 4'h0});
      for (int s = 0; s < 4; s++) begin
        @(posedge mclk) src <= 4'h1 << s;
        @(posedge mclk) src <= 4'h0;
        #1;
        chk("irq pin", {7'h0, SRCM[c][s]}, {7'h0, pin_o});
        tick(14);
        chk("single pulse", 8'h00, {7'h0, pin_o});
      end
    end
    chk("irq", 8'h01, {7'h0, irq});
    wr_reg(`SMP_ADDR_CTRL, 8'hC0);
    tick(2);
    chk("oe", 8'h00, {7'h0, pin_oe});
    // Repeating pulses stopped by a flag read
    wr_reg(`SMP_ADDR_CTRL, 8'hA2);
    @(posedge mclk) src <= 4'h8;
    @(posedge mclk) src <= 4'h0;
    tick(9);
    chk("gap", 8'h00, {7'h0, pin_o});
    tick(5);
    chk("repeat", 8'h01, {7'h0, pin_o});
    @(posedge mclk) flag <= 1'b1;
    @(posedge mclk) flag <= 1'b0;
    tick(11);
    chk("stopped", 8'h00, {7'h0, pin_o});
    // Microphone data on both clock edges
    for (int c = 5; c < 8; c++) begin
      wr_reg(`SMP_ADDR_CTRL, {4'(c), 4'h0});
      @(posedge mclk) val <= c[0];
      @(posedge mclk) mck <= 1'b1;
      tick(3);
      @(posedge mclk) val <= ~c[0];
      @(posedge mclk) mck <= 1'b0;
      tick(1);
      chk("mic valid", 8'h01, {7'h0, mval});
      tick(2);
      chk("mic", {6'h0, c[0], ~c[0]}, {6'h0, mrise, mfall});
      chk("mic valid", 8'h00, {7'h0, mval});
    end
    // Bit clock out, then in
    wr_reg(`SMP_ADDR_CTRL, 8'h80);
    @(posedge mclk) {bdir, bsrc} <= 2'h3;
    tick(3);
    chk("bclk out", 8'h03, {6'h0, pin_oe, pin_o});
    @(posedge mclk) {bdir, val} <= 2'h0;
    tick(4);
    chk("bclk in", 8'h00, {6'h0, pin_oe, bclk});
    close_out();
  end
endmodule
